// ==== mhl_pkg.sv ====
//==============================================================================
//==============================================================================
package mhl_pkg;

    localparam int          CH_NUM      = 4;
    localparam logic [23:0] OFFSET_MAX  = 24'h98_967F;
    localparam logic [13:0] JOG_MAX     = 14'h270F;
    localparam logic [7:0]  ASCII_ZERO  = 8'h30;
    localparam logic [7:0]  ASCII_A     = 8'h41;
    localparam logic [47:0] TXT_NO_HOME = 48'h4E4F_2048_2E50;
    localparam logic [23:0] OFFSET_RST  = 24'h00_0000;
    localparam logic [13:0] JOG_RST     = 14'h0000;
    localparam logic [3:0]  DIGITS_JOG  = 4'h4;

    // Decoded command codes from the link parser
    typedef enum logic [3:0] {
        OP_HOME_CONFIG_SET    = 4'b0000,
        OP_HOME_CONFIG_QUERY  = 4'b0001,
        OP_HOME_VALUE_FORCE   = 4'b0010,
        OP_HOME_VALUE_QUERY   = 4'b0011,
        OP_HOME_OFFSET_SET    = 4'b0100,
        OP_HOME_OFFSET_QUERY  = 4'b0101,
        OP_HOME_SEARCH_GO     = 4'b0110,
        OP_PRESET_SET         = 4'b0111,
        OP_PRESET_QUERY       = 4'b1000,
        OP_JOG_COUNT_SET      = 4'b1001,
        OP_JOG_COUNT_QUERY    = 4'b1010,
        OP_LIMIT_ENABLE_SET   = 4'b1011,
        OP_LIMIT_ENABLE_QUERY = 4'b1100,
        OP_LIMIT_STATE_QUERY  = 4'b1101
    } mhl_op_t;

endpackage

// ==== mhl_param_cmd.sv ====
`timescale 1ns/1ps
module mhl_param_cmd
    import mhl_pkg::*;
(
    input  wire logic               i_mclk,
    input  wire logic               i_srst,
    input  wire logic               i_ce,
    input  wire logic               i_remote,
    input  wire logic               i_cmd_valid,
    input  wire logic [3:0]         i_cmd_op,
    input  wire logic [3:0]         i_cmd_chan,
    input  wire logic [31:0]        i_cmd_digits,
    input  wire logic [31:0]        i_cmd_value,
    input  wire logic [3:0]         i_step_pulse,
    input  wire logic [3:0]         i_home_sw,
    input  wire logic [3:0]         i_cw_sw,
    input  wire logic [3:0]         i_ccw_sw,
    input  wire logic [3:0]         i_soft_cw,
    input  wire logic [3:0]         i_soft_ccw,
    input  wire logic [3:0][31:0]   i_cur_pos,
    input  wire logic [1:0]         i_local_chan,
    input  wire logic               i_scan_mode,
    input  wire logic               i_preset_btn,
    input  wire logic               i_jog_req,
    input  wire logic               i_jog_ccw,
    output logic                    o_rsp_valid,
    output logic                    o_rsp_ok,
    output logic [3:0]              o_rsp_op,
    output logic                    o_rsp_is_text,
    output logic [63:0]             o_rsp_text,
    output logic [3:0]              o_rsp_len,
    output logic [31:0]             o_rsp_value,
    output logic [3:0]              o_rsp_digits,
    output logic [3:0]              o_home_found,
    output logic [3:0]              o_detect_ccw,
    output logic [3:0]              o_start_ccw,
    output logic [3:0]              o_soft_lim_en,
    output logic [3:0]              o_ls_en,
    output logic                    o_search_go,
    output logic [1:0]              o_search_chan,
    output logic [23:0]             o_search_offset,
    output logic [3:0]              o_search_busy,
    output logic                    o_search_fail,
    output logic [1:0]              o_search_fail_chan,
    output logic [31:0]             o_preset_disp,
    output logic                    o_load_pos,
    output logic [1:0]              o_load_chan,
    output logic [31:0]             o_load_value,
    output logic                    o_jog_go,
    output logic [1:0]              o_jog_chan,
    output logic                    o_jog_dir_ccw,
    output logic [13:0]             o_jog_steps
);

    //==========================================================================
    // Helpers
    //==========================================================================
    // A field digit is legal only as 0 or 1
    function automatic logic is_bit(input logic [3:0] nib);
        return nib <= 4'h1;
    endfunction

    function automatic logic [7:0] hex_char(input logic [3:0] nib);
        return (nib < 4'hA) ? ASCII_ZERO + {4'h0, nib} : ASCII_A + {4'h0, nib} - 8'h0A;
    endfunction

    //==========================================================================
    // Stored parameters
    //==========================================================================
    logic [3:0]         found_ff;
    logic [3:0]         det_ccw_ff;
    logic [3:0]         start_ccw_ff;
    logic [3:0]         dig_en_ff;
    logic [3:0]         ls_en_ff;
    logic [3:0]         busy_ff;
    logic [31:0]        home_val_ff  [CH_NUM];
    logic [23:0]        offset_ff    [CH_NUM];
    logic [31:0]        preset_ff    [CH_NUM];
    logic [13:0]        jog_ff       [CH_NUM];
    logic [24:0]        srch_cnt_ff  [CH_NUM];

    //==========================================================================
    // Command decode
    //==========================================================================
    mhl_op_t            op;
    logic [1:0]         ch;
    logic               chan_ok;
    logic               is_set;
    logic               fields_ok;
    logic               do_set;
    logic               do_query;
    logic [3:0]         d0, d1, d2, d3, d4;
    logic [23:0]        offset_clamped;
    logic [3:0]         hit;
    logic [3:0]         miss;

    assign op      = mhl_op_t'(i_cmd_op);
    assign ch      = i_cmd_chan[1:0];
    assign chan_ok = i_cmd_chan < 4'h4 || op == OP_LIMIT_STATE_QUERY;
    assign d0      = i_cmd_digits[31:28];
    assign d1      = i_cmd_digits[27:24];
    assign d2      = i_cmd_digits[23:20];
    assign d3      = i_cmd_digits[19:16];
    assign d4      = i_cmd_digits[15:12];

    // Field checks per command; only set-type commands carry digits
    always_comb begin
        is_set    = 1'b0;
        fields_ok = 1'b1;
        case (op)
            OP_HOME_CONFIG_SET: begin
                is_set    = 1'b1;
                fields_ok = d0 == 4'h0 && is_bit(d1) && is_bit(d2) && is_bit(d3);
            end
            OP_LIMIT_ENABLE_SET: begin
                is_set    = 1'b1;
                fields_ok = is_bit(d0) && is_bit(d1) && d2 == d1 && d3 == d1;
            end
            OP_JOG_COUNT_SET: begin
                is_set    = 1'b1;
                fields_ok = i_cmd_value <= {18'h0_0000, JOG_MAX};
            end
            OP_HOME_VALUE_FORCE, OP_HOME_OFFSET_SET, OP_PRESET_SET, OP_HOME_SEARCH_GO: begin
                is_set = 1'b1;
            end
            OP_HOME_CONFIG_QUERY, OP_HOME_VALUE_QUERY, OP_HOME_OFFSET_QUERY, OP_PRESET_QUERY,
            OP_JOG_COUNT_QUERY, OP_LIMIT_ENABLE_QUERY, OP_LIMIT_STATE_QUERY: begin
                is_set = 1'b0;
            end
            default: begin
                fields_ok = 1'b0;
            end
        endcase
    end

    // Setting only in remote; queries in either mode
    assign do_set   = i_cmd_valid && is_set && i_remote && chan_ok && fields_ok;
    assign do_query = i_cmd_valid && !is_set && chan_ok && fields_ok;

    // Negative offsets clamp to zero, large ones to the top of range
    assign offset_clamped = i_cmd_value[31] ? OFFSET_RST :
                            (i_cmd_value > {8'h00, OFFSET_MAX}) ? OFFSET_MAX : i_cmd_value[23:0];

    // Search outcome per channel: switch seen, or twice the offset travelled without it
    always_comb begin
        for (int i = 0; i < CH_NUM; i++) begin
            hit[i]  = busy_ff[i] && i_home_sw[i];
            miss[i] = busy_ff[i] && !i_home_sw[i] && srch_cnt_ff[i] >= {offset_ff[i], 1'b0};
        end
    end

    //==========================================================================
    // Home configuration and found flags
    //==========================================================================
    // Search result is applied before the command, which ORs in the hit so a hit is never lost
    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            found_ff     <= 4'h0;
            det_ccw_ff   <= 4'h0;
            start_ccw_ff <= 4'h0;
        end else if (i_ce) begin
            if (do_set && op == OP_HOME_CONFIG_SET) begin
                det_ccw_ff[ch]   <= d2[0];
                start_ccw_ff[ch] <= d3[0];
            end
            found_ff <= found_ff & ~miss | hit;
            // Command overrides the search outcome on its own channel; a hit still sets
            if (do_set && (op == OP_HOME_CONFIG_SET || op == OP_HOME_VALUE_FORCE)) begin
                found_ff[ch] <= (op == OP_HOME_VALUE_FORCE) | d1[0] | hit[ch];
            end
        end
    end

    //==========================================================================
    // Home value, offset, search counter
    //==========================================================================
    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            busy_ff <= 4'h0;
            for (int i = 0; i < CH_NUM; i++) begin
                home_val_ff[i] <= 32'h0000_0000;
                offset_ff[i]   <= OFFSET_RST;
                srch_cnt_ff[i] <= 25'h000_0000;
            end
        end else if (i_ce) begin
            for (int i = 0; i < CH_NUM; i++) begin
                if (hit[i]) begin
                    home_val_ff[i] <= i_cur_pos[i];
                    busy_ff[i]     <= 1'b0;
                end else if (miss[i]) begin
                    home_val_ff[i] <= 32'h0000_0000;
                    busy_ff[i]     <= 1'b0;
                end else if (busy_ff[i] && i_step_pulse[i]) begin
                    srch_cnt_ff[i] <= srch_cnt_ff[i] + 25'h000_0001;
                end
            end
            if (do_set && op == OP_HOME_VALUE_FORCE) begin
                home_val_ff[ch] <= i_cmd_value;
            end
            if (do_set && op == OP_HOME_OFFSET_SET) begin
                offset_ff[ch] <= offset_clamped;
            end
            // A new search restarts the travel count from zero when the command is taken
            if (do_set && op == OP_HOME_SEARCH_GO) begin
                busy_ff[ch]     <= 1'b1;
                srch_cnt_ff[ch] <= 25'h000_0000;
            end
        end
    end

    //==========================================================================
    // Preset, jog count, limit enables
    //==========================================================================
    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            dig_en_ff <= 4'h0;
            ls_en_ff  <= 4'h0;
            for (int i = 0; i < CH_NUM; i++) begin
                preset_ff[i] <= 32'h0000_0000;
                jog_ff[i]    <= JOG_RST;
            end
        end else if (i_ce && do_set) begin
            case (op)
                OP_PRESET_SET:       preset_ff[ch] <= i_cmd_value;
                OP_JOG_COUNT_SET:    jog_ff[ch]    <= i_cmd_value[13:0];
                OP_LIMIT_ENABLE_SET: begin
                    dig_en_ff[ch] <= d0[0];
                    ls_en_ff[ch]  <= d1[0];
                end
                default:             ;
            endcase
        end
    end

    //==========================================================================
    // Search and local-mode motion requests
    //==========================================================================
    // Preset and jog are front-panel features; remote motion ignores them
    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            o_search_go        <= 1'b0;
            o_search_chan      <= 2'b00;
            o_search_offset    <= OFFSET_RST;
            o_search_fail      <= 1'b0;
            o_search_fail_chan <= 2'b00;
            o_preset_disp      <= 32'h0000_0000;
            o_load_pos         <= 1'b0;
            o_load_chan        <= 2'b00;
            o_load_value       <= 32'h0000_0000;
            o_jog_go           <= 1'b0;
            o_jog_chan         <= 2'b00;
            o_jog_dir_ccw      <= 1'b0;
            o_jog_steps        <= JOG_RST;
        end else if (i_ce) begin
            o_search_go     <= do_set && op == OP_HOME_SEARCH_GO;
            o_search_chan   <= ch;
            o_search_offset <= offset_ff[ch];
            o_search_fail   <= |miss;
            for (int i = CH_NUM - 1; i >= 0; i--) begin
                if (miss[i]) begin
                    o_search_fail_chan <= 2'(i);
                end
            end
            o_preset_disp <= (!i_remote && i_scan_mode) ? preset_ff[i_local_chan] : 32'h0000_0000;
            o_load_pos    <= !i_remote && i_scan_mode && i_preset_btn;
            o_load_chan   <= i_local_chan;
            o_load_value  <= preset_ff[i_local_chan];
            o_jog_go      <= !i_remote && i_jog_req;
            o_jog_chan    <= i_local_chan;
            o_jog_dir_ccw <= i_jog_ccw;
            o_jog_steps   <= jog_ff[i_local_chan];
        end
    end

    //==========================================================================
    // Replies
    //==========================================================================
    logic [3:0] lim_state [CH_NUM];

    // Home bit is the bare switch; only cw and ccw take software limits
    always_comb begin
        for (int i = 0; i < CH_NUM; i++) begin
            lim_state[i] = {1'b0, i_home_sw[i],
                            (i_ccw_sw[i] & ls_en_ff[i]) | (i_soft_ccw[i] & dig_en_ff[i]),
                            (i_cw_sw[i] & ls_en_ff[i]) | (i_soft_cw[i] & dig_en_ff[i])};
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            o_rsp_valid   <= 1'b0;
            o_rsp_ok      <= 1'b0;
            o_rsp_op      <= 4'h0;
            o_rsp_is_text <= 1'b0;
            o_rsp_text    <= 64'h0000_0000_0000_0000;
            o_rsp_len     <= 4'h0;
            o_rsp_value   <= 32'h0000_0000;
            o_rsp_digits  <= 4'h0;
        end else if (i_ce) begin
            o_rsp_valid   <= i_cmd_valid;
            o_rsp_ok      <= do_set || do_query;
            o_rsp_op      <= i_cmd_op;
            o_rsp_is_text <= 1'b0;
            o_rsp_text    <= 64'h0000_0000_0000_0000;
            o_rsp_len     <= 4'h0;
            o_rsp_value   <= 32'h0000_0000;
            o_rsp_digits  <= 4'h0;
            if (do_query) begin
                case (op)
                    OP_HOME_CONFIG_QUERY: begin
                        o_rsp_is_text <= 1'b1;
                        o_rsp_len     <= 4'h4;
                        o_rsp_text    <= {ASCII_ZERO, hex_char({3'b000, found_ff[ch]}),
                                          hex_char({3'b000, det_ccw_ff[ch]}),
                                          hex_char({3'b000, start_ccw_ff[ch]}), 32'h0000_0000};
                    end
                    OP_HOME_VALUE_QUERY: begin
                        if (found_ff[ch]) begin
                            o_rsp_value <= home_val_ff[ch];
                        end else begin
                            o_rsp_is_text <= 1'b1;
                            o_rsp_len     <= 4'h6;
                            o_rsp_text    <= {TXT_NO_HOME, 16'h0000};
                        end
                    end
                    OP_HOME_OFFSET_QUERY: o_rsp_value <= {8'h00, offset_ff[ch]};
                    OP_PRESET_QUERY:      o_rsp_value <= preset_ff[ch];
                    OP_JOG_COUNT_QUERY: begin
                        o_rsp_value  <= {18'h0_0000, jog_ff[ch]};
                        o_rsp_digits <= DIGITS_JOG;
                    end
                    OP_LIMIT_ENABLE_QUERY: begin
                        o_rsp_is_text <= 1'b1;
                        o_rsp_len     <= 4'h8;
                        o_rsp_text    <= {hex_char({3'b000, dig_en_ff[ch]}), {3{hex_char({3'b000, ls_en_ff[ch]})}},
                                          ASCII_ZERO, {3{hex_char({3'b000, ls_en_ff[ch]})}}};
                    end
                    OP_LIMIT_STATE_QUERY: begin
                        o_rsp_is_text <= 1'b1;
                        o_rsp_len     <= 4'h8;
                        o_rsp_text    <= {hex_char(4'h0), hex_char(4'h1), hex_char(4'h2), hex_char(4'h3),
                                          hex_char(lim_state[0]), hex_char(lim_state[1]),
                                          hex_char(lim_state[2]), hex_char(lim_state[3])};
                    end
                    default: ;
                endcase
            end
        end
    end

    assign o_home_found  = found_ff;
    assign o_detect_ccw  = det_ccw_ff;
    assign o_start_ccw   = start_ccw_ff;
    assign o_soft_lim_en = dig_en_ff;
    assign o_ls_en       = ls_en_ff;
    assign o_search_busy = busy_ff;

    //==========================================================================
    // Checks
    //==========================================================================
    property p_set_local_refused;
        @(posedge i_mclk) disable iff (i_srst || !i_ce)
        i_cmd_valid && is_set && !i_remote |=> o_rsp_valid && !o_rsp_ok;
    endproperty
    a_set_local_refused: assert property (p_set_local_refused) else $error("set accepted in local");

    property p_bad_chan_stable;
        @(posedge i_mclk) disable iff (i_srst || !i_ce)
        i_cmd_valid && i_cmd_chan >= 4'h4 && op != OP_LIMIT_STATE_QUERY && busy_ff == 4'h0
            |=> $stable(found_ff) && $stable(ls_en_ff) && $stable(dig_en_ff) && !o_rsp_ok;
    endproperty
    a_bad_chan_stable: assert property (p_bad_chan_stable) else $error("bad channel changed state");

    property p_offset_range;
        @(posedge i_mclk) disable iff (i_srst)
        offset_ff[0] <= OFFSET_MAX && offset_ff[3] <= OFFSET_MAX;
    endproperty
    a_offset_range: assert property (p_offset_range) else $error("offset above range");

    property p_force_sets_found;
        @(posedge i_mclk) disable iff (i_srst || !i_ce)
        do_set && op == OP_HOME_VALUE_FORCE |=> found_ff[$past(ch)] && home_val_ff[$past(ch)] == $past(i_cmd_value);
    endproperty
    a_force_sets_found: assert property (p_force_sets_found) else $error("forced home not stored");

    property p_fail_erases;
        @(posedge i_mclk) disable iff (i_srst || !i_ce)
        o_search_fail && !$past(do_set)
            |-> !found_ff[o_search_fail_chan] && home_val_ff[o_search_fail_chan] == 32'h0000_0000;
    endproperty
    a_fail_erases: assert property (p_fail_erases) else $error("failed search kept home");

    property p_jog_local_only;
        @(posedge i_mclk) disable iff (i_srst || !i_ce)
        i_remote |=> !o_jog_go && !o_load_pos;
    endproperty
    a_jog_local_only: assert property (p_jog_local_only) else $error("jog or preset in remote");

    property p_limit_home_bit;
        @(posedge i_mclk) disable iff (i_srst || !i_ce)
        do_query && op == OP_LIMIT_STATE_QUERY && !i_home_sw[3]
            |=> o_rsp_text[2] == 1'b0 && o_rsp_text[7:3] == 5'b00110;
    endproperty
    a_limit_home_bit: assert property (p_limit_home_bit) else $error("home limit bit not physical");

    property p_ls_mixed_refused;
        @(posedge i_mclk) disable iff (i_srst || !i_ce)
        i_cmd_valid && op == OP_LIMIT_ENABLE_SET && (d2 != d1 || d3 != d1)
            |=> !o_rsp_ok && $stable(ls_en_ff);
    endproperty
    a_ls_mixed_refused: assert property (p_ls_mixed_refused) else $error("mixed limit enables taken");

    property p_config_reply;
        @(posedge i_mclk) disable iff (i_srst || !i_ce)
        do_query && op == OP_HOME_CONFIG_QUERY |=> o_rsp_text[63:56] == ASCII_ZERO && o_rsp_len == 4'h4;
    endproperty
    a_config_reply: assert property (p_config_reply) else $error("config reply malformed");

endmodule // mhl_param_cmd

// ==== mhl_host.sv ====
`timescale 1ns/1ps
module mhl_host
    import mhl_pkg::*;
(
    input  wire logic        i_mclk,
    output logic             o_cmd_valid,
    output logic [3:0]       o_cmd_op,
    output logic [3:0]       o_cmd_chan,
    output logic [31:0]      o_cmd_digits,
    output logic [31:0]      o_cmd_value
);
    // Idle link: nothing offered at time zero
    initial {o_cmd_valid, o_cmd_op, o_cmd_chan, o_cmd_digits, o_cmd_value} = '0;
    // One parsed command, offered for exactly one edge
    task automatic send(input logic [3:0] op, ch, input logic [31:0] dg, v);
        @(posedge i_mclk);
        #1;
        o_cmd_op = op;
        o_cmd_chan = ch;
        o_cmd_digits = dg;
        o_cmd_value = v;
        o_cmd_valid = 1'b1;
        @(posedge i_mclk);
        #1;
        o_cmd_valid = 1'b0;
        // Stale digits and value flipped so the block cannot lean on them
        o_cmd_digits = ~dg;
        o_cmd_value = ~v;
    endtask
endmodule // mhl_host

// ==== tb_mhl_param_cmd.sv ====
`timescale 1ns/1ps
module tb_mhl_param_cmd
    import mhl_pkg::*;
;
    logic i_mclk = 0, i_srst = 1, i_ce = 1, i_remote = 1, i_scan_mode = 0, i_preset_btn = 0, i_jog_req = 0, i_jog_ccw = 0;
    logic [1:0] i_local_chan = 0;
    logic [3:0] i_step_pulse = 0, i_home_sw = 0, i_cw_sw = 0, i_ccw_sw = 0, i_soft_cw = 0, i_soft_ccw = 0;
    logic [3:0][31:0] i_cur_pos = '0;
    logic i_cmd_valid, o_rsp_valid, o_rsp_ok, o_rsp_is_text, o_search_fail, o_load_pos, o_jog_go, o_jog_dir_ccw;
    logic [3:0] i_cmd_op, i_cmd_chan, o_rsp_digits, o_home_found, o_detect_ccw, o_start_ccw, o_soft_lim_en, o_ls_en;
    logic [31:0] i_cmd_digits, i_cmd_value, o_rsp_value, o_preset_disp, o_load_value;
    logic [63:0] o_rsp_text;
    logic [13:0] o_jog_steps;
    logic o_search_go;
    logic [1:0] o_search_chan, o_search_fail_chan, o_load_chan, o_jog_chan;
    logic [3:0] o_rsp_op, o_rsp_len, o_search_busy;
    logic [23:0] o_search_offset;
    int bad_count = 0, check_count = 0, cyc = 0;

    mhl_host mhl_host_i(.i_mclk, .o_cmd_valid(i_cmd_valid), .o_cmd_op(i_cmd_op), .o_cmd_chan(i_cmd_chan),
        .o_cmd_digits(i_cmd_digits), .o_cmd_value(i_cmd_value));
    mhl_param_cmd mhl_param_cmd_i(.i_mclk, .i_srst, .i_ce, .i_remote, .i_cmd_valid, .i_cmd_op, .i_cmd_chan,
        .i_cmd_digits, .i_cmd_value, .i_step_pulse, .i_home_sw, .i_cw_sw, .i_ccw_sw, .i_soft_cw, .i_soft_ccw,
        .i_cur_pos, .i_local_chan, .i_scan_mode, .i_preset_btn, .i_jog_req, .i_jog_ccw, .o_rsp_valid, .o_rsp_ok,
        .o_rsp_op, .o_rsp_is_text, .o_rsp_text, .o_rsp_len, .o_rsp_value, .o_rsp_digits, .o_home_found,
        .o_detect_ccw, .o_start_ccw, .o_soft_lim_en, .o_ls_en, .o_search_go, .o_search_chan,
        .o_search_offset, .o_search_busy, .o_search_fail, .o_search_fail_chan, .o_preset_disp,
        .o_load_pos, .o_load_chan, .o_load_value, .o_jog_go, .o_jog_chan, .o_jog_dir_ccw, .o_jog_steps);

    //==========================================================================
    // Helpers
    //==========================================================================
    // Clock, 50 ns period
    always #25 i_mclk = ~i_mclk;
    // Hang guard, generous against roughly 74 busy cycles
    always @(posedge i_mclk) begin
        cyc++;
        if (cyc == 3000) begin
            bad_count++;
            stop_test();
        end
    end
    task automatic stop_test();
        $display("Comparisons %0d, mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input logic [63:0] s, e);
        check_count++;
        if (s !== e) begin
            bad_count++;
            $display("Error %0t: seen %h expected %h", $time, s, e);
        end
    endtask
    // Command plus its acceptance flag, reply sampled one cycle later
    task automatic cmd(input mhl_op_t op, input logic [3:0] ch, input logic [31:0] dg, v, input logic ok);
        mhl_host_i.send(op, ch, dg, v);
        chk(o_rsp_valid, 1'b1);
        chk(o_rsp_ok, ok);
        chk(o_rsp_op, op);
    endtask
    task automatic tick();
        @(posedge i_mclk);
        #1;
    endtask

    //==========================================================================
    // Scenarios
    //==========================================================================
    // Main sequence; front-panel pulses last one edge each
    initial begin
        repeat (16) @(posedge i_mclk);
        #1 i_srst = 0;
        cmd(OP_HOME_CONFIG_SET, 4'h1, 32'h0110_0000, 0, 1);
        chk({o_home_found, o_detect_ccw, o_start_ccw}, 12'h220);
        cmd(OP_HOME_CONFIG_SET, 4'h1, 32'h0201_0000, 0, 0);
        cmd(OP_HOME_CONFIG_SET, 4'h4, 32'h0000_0000, 0, 0);
        cmd(OP_HOME_CONFIG_QUERY, 4'h1, 0, 0, 1);
        chk(o_rsp_text, 64'h3031_3130_0000_0000);
        chk(o_rsp_len, 4'h4);
        chk({o_home_found, o_detect_ccw, o_start_ccw}, 12'h220);
        cmd(OP_HOME_VALUE_FORCE, 4'h0, 0, 32'hFFFF_FFFB, 1);
        cmd(OP_HOME_VALUE_QUERY, 4'h0, 0, 0, 1);
        chk({o_rsp_is_text, o_rsp_value}, 33'h0_FFFF_FFFB);
        cmd(OP_HOME_VALUE_QUERY, 4'h3, 0, 0, 1);
        chk(o_rsp_text, {TXT_NO_HOME, 16'h0000});
        cmd(OP_HOME_OFFSET_SET, 4'h2, 0, 32'h0098_9680, 1);
        cmd(OP_HOME_OFFSET_QUERY, 4'h2, 0, 0, 1);
        chk(o_rsp_value, 32'h0098_967F);
        cmd(OP_HOME_OFFSET_SET, 4'h1, 0, 32'h0000_0001, 1);
        cmd(OP_HOME_SEARCH_GO, 4'h1, 0, 0, 1);
        i_step_pulse = 4'h2;
        repeat (2) tick();
        i_step_pulse = 4'h0;
        for (int k = 0; k < 4 && o_search_fail !== 1'b1; k++) tick();
        chk({o_search_fail, o_home_found[1], o_search_fail_chan}, 4'h9);
        // Switch hit while searching captures the current position
        i_cur_pos[2] = 32'h0000_0042;
        cmd(OP_HOME_SEARCH_GO, 4'h2, 0, 0, 1);
        chk({o_search_go, o_search_chan, o_search_offset, o_search_busy}, {1'b1, 2'h2, 24'h98_967F, 4'h4});
        i_home_sw = 4'h4;
        tick();
        i_home_sw = 4'h0;
        cmd(OP_HOME_VALUE_QUERY, 4'h2, 0, 0, 1);
        chk({o_home_found[2], o_search_busy[2], o_rsp_value}, {2'b10, 32'h0000_0042});
        cmd(OP_JOG_COUNT_SET, 4'h0, 0, 32'h0000_2710, 0);
        cmd(OP_JOG_COUNT_SET, 4'h0, 0, 32'h0000_270F, 1);
        cmd(OP_JOG_COUNT_QUERY, 4'h0, 0, 0, 1);
        chk({o_rsp_digits, o_rsp_value}, 36'h4_0000_270F);
        cmd(OP_PRESET_SET, 4'h0, 0, 32'h0000_0007, 1);
        // Clock enable low: command ignored, preset kept
        tick();
        i_ce = 0;
        mhl_host_i.send(OP_PRESET_SET, 4'h0, 0, 32'h0000_0005);
        chk(o_rsp_valid, 1'b0);
        i_ce = 1;
        cmd(OP_PRESET_QUERY, 4'h0, 0, 0, 1);
        chk(o_rsp_value, 32'h0000_0007);
        cmd(OP_LIMIT_ENABLE_SET, 4'h3, 32'h1111_0111, 0, 1);
        cmd(OP_LIMIT_ENABLE_SET, 4'h2, 32'h1110_0111, 0, 0);
        chk({o_soft_lim_en, o_ls_en}, 8'h88);
        cmd(OP_LIMIT_ENABLE_QUERY, 4'h3, 0, 0, 1);
        chk(o_rsp_text, 64'h3131_3131_3031_3131);
        i_home_sw = 4'h1;
        i_soft_cw = 4'hF;
        cmd(OP_LIMIT_STATE_QUERY, 4'h0, 0, 0, 1);
        chk(o_rsp_text, 64'h3031_3233_3430_3031);
        i_jog_req = 1;
        tick();
        i_jog_req = 0;
        chk(o_jog_go, 1'b0);
        i_remote = 0;
        cmd(OP_HOME_VALUE_FORCE, 4'h0, 0, 32'h0000_0003, 0);
        cmd(OP_HOME_VALUE_QUERY, 4'h0, 0, 0, 1);
        chk(o_rsp_value, 32'hFFFF_FFFB);
        {i_scan_mode, i_jog_ccw, i_jog_req} = 3'h7;
        tick();
        i_jog_req = 0;
        chk({o_jog_go, o_jog_dir_ccw, o_jog_chan, o_jog_steps}, 18'h3_270F);
        chk(o_preset_disp, 32'h0000_0007);
        i_preset_btn = 1;
        tick();
        i_preset_btn = 0;
        chk({o_load_pos, o_load_chan, o_load_value}, 35'h4_0000_0007);
        stop_test();
    end
endmodule // tb_mhl_param_cmd
